// File: design/host_control_port.sv
// host control port: serial 1, spi slave, attention, cts, relays, pin modes
`timescale 1ns/1ps
`include "host_port_cfg.svh"
//Function
//- attention goes low while i2c data waits for the master, outside rs422/485 mode
//- in rs422/485 mode attention is low throughout serial transmit
//- one clear-to-send output throttles host before receive buffer overflows
//- spi slave: takes sck and mosi, drives miso back
//- serial 1 receives on host-transmit pin, sends on host-receive pin
//- low on reset-capable pin, when configured, resets the module except the power-up and erase-strap registers
//- reset-capable pin, when configured, also shows the internal power-up reset
//- serial 1 receive line (host-transmit pin) low at power-up requests user flash erase
//- each switch output is static on/off or a pwm channel
//- first-group pins: input, push-pull, pull-down or keyboard column
//- i2c pins: input, pull-down or keyboard column only, no push-pull
//- general pins add an analog input function
module host_control_port #(
	parameter int DATA_W = `BYTE_W,
	parameter int PWM_W  = `PWM_W
) (
	input  wire logic                          clk,
	input  wire logic                          reset,
	input  wire logic                          serial1_host_to_device,
	output logic                               serial1_device_to_host,
	output logic                               cts_n,
	output logic                               attention_n,
	input  wire logic                          rs485_mode,
	input  wire logic                          i2c_pending,
	input  wire logic                          spi_sck,
	input  wire logic                          spi_mosi,
	output logic                               spi_miso,
	input  wire logic                          spi_sel_n,
	input  wire logic [DATA_W-1:0]             spi_tx_byte,
	output logic [DATA_W-1:0]                  rx_data,
	output logic                               rx_valid,
	input  wire logic                          rx_ready,
	input  wire logic [DATA_W-1:0]             tx_data,
	input  wire logic                          tx_valid,
	output logic                               tx_ready,
	input  wire logic                          reset_pin_enable,
	input  wire logic                          reset_pin_in,
	output logic                               reset_pin_out,
	output logic                               reset_pin_oe,
	output logic                               module_reset,
	output logic                               erase_request,
	input  wire logic [1:0]                    switch_pwm_mode,
	input  wire logic [1:0]                    switch_static,
	input  wire logic [PWM_W-1:0]              pwm_duty_0,
	input  wire logic [PWM_W-1:0]              pwm_duty_1,
	output logic                               switch_out_0,
	output logic                               switch_out_1,
	input  wire host_port_pkg::pin_mode_type   mode_sda,
	input  wire host_port_pkg::pin_mode_type   mode_gio_a,
	input  wire logic                          gio_a_level,
	input  wire logic                          sda_level,
	output host_port_pkg::pin_drive_type       sda_drive,
	output host_port_pkg::pin_drive_type       general_io_a_drive,
	output logic                               general_io_a_analog
);
	// ****************************************
	// input synchronisers
	// ****************************************
	logic [1:0] rx_s_r, sck_s_r, mosi_s_r, sel_s_r, rst_s_r;
	logic       sck_d_r;
	always_ff @(posedge clk) begin
		rx_s_r   <= {rx_s_r[0], serial1_host_to_device};
		sck_s_r  <= {sck_s_r[0], spi_sck};
		mosi_s_r <= {mosi_s_r[0], spi_mosi};
		sel_s_r  <= {sel_s_r[0], spi_sel_n};
		rst_s_r  <= {rst_s_r[0], reset_pin_in};
		sck_d_r  <= sck_s_r[1];
	end
	wire rx_pin   = rx_s_r[1];
	wire sck_rise = sck_s_r[1] & ~sck_d_r;
	wire sck_fall = ~sck_s_r[1] & sck_d_r;
	wire spi_sel  = ~sel_s_r[1];
	// ****************************************
	// reset pin and power-up
	// ****************************************
	logic por_r, erase_r, ext_rst_r;
	wire  ext_rst = reset_pin_enable & ~rst_s_r[1];
	always_ff @(posedge clk) begin
		if (reset) begin
			por_r   <= 1'b1;
			erase_r <= 1'b0;
		end else begin
			por_r <= 1'b0;
			if (por_r)
				erase_r <= ~rx_pin;
		end
		// cleared by reset so an unsettled pin sync cannot hold the core in reset
		ext_rst_r <= ~reset & ext_rst;
	end
	assign module_reset  = ext_rst_r;
	assign erase_request = erase_r;
	// open-drain: show power-up reset by pulling low
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe  = reset_pin_enable & por_r;
	wire rst = reset | ext_rst_r;
	// ****************************************
	// serial receive into two-entry buffer
	// ****************************************
	logic [15:0]       rdiv_r;
	logic [2:0]        rbit_r;
	logic [1:0]        rph_r;
	logic [DATA_W-1:0] rsh_r;
	logic              rdone_r;
	always_ff @(posedge clk) begin
		rdone_r <= 1'b0;
		if (rst) begin
			rph_r  <= 2'b00;
			rdiv_r <= 16'h0000;
			rbit_r <= 3'h0;
			rsh_r  <= '0;
		end else if (rph_r == 2'b00) begin
			rdiv_r <= `UART_HALF;
			if (!rx_pin) rph_r <= 2'b01;
		end else if (rdiv_r != 16'h0000) begin
			rdiv_r <= rdiv_r - 16'h0001;
		end else begin
			rdiv_r <= `UART_DIV;
			case (rph_r)
				2'b01: begin
					rph_r  <= rx_pin ? 2'b00 : 2'b10;
					rbit_r <= 3'h0;
				end
				2'b10: begin
					rsh_r  <= {rx_pin, rsh_r[DATA_W-1:1]};
					rbit_r <= rbit_r + 3'h1;
					if (rbit_r == `BIT_LAST) rph_r <= 2'b11;
				end
				default: begin
					rph_r   <= 2'b00;
					rdone_r <= rx_pin;
				end
			endcase
		end
	end
	logic [DATA_W-1:0] buf_r [`BUF_DEPTH];
	logic [1:0]        cnt_r;
	logic              wp_r, rp_r;
	wire push = rdone_r & (cnt_r != 2'd2);
	wire pop  = (cnt_r != 2'd0) & rx_ready;
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 2'd0;
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
		end else begin
			if (push) begin
				buf_r[wp_r] <= rsh_r;
				wp_r        <= ~wp_r;
			end
			if (pop) rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
	assign rx_data  = buf_r[rp_r];
	assign rx_valid = (cnt_r != 2'd0);
	// throttle once one entry is used, leaving room for a byte in flight
	logic cts_r;
	always_ff @(posedge clk) cts_r <= rst ? 1'b0 : (cnt_r != 2'd0);
	assign cts_n = cts_r;
	// ****************************************
	// serial transmit
	// ****************************************
	host_port_pkg::tx_state_type ts_r;
	logic [15:0]       tdiv_r;
	logic [2:0]        tbit_r;
	logic [DATA_W-1:0] tsh_r;
	logic              tline_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			ts_r    <= host_port_pkg::tx_idle;
			tline_r <= 1'b1;
			tdiv_r  <= 16'h0000;
			tbit_r  <= 3'h0;
			tsh_r   <= '0;
		end else if (ts_r == host_port_pkg::tx_idle) begin
			if (tx_valid) begin
				tsh_r   <= tx_data;
				ts_r    <= host_port_pkg::tx_start;
				tline_r <= 1'b0;
				tdiv_r  <= `UART_DIV;
			end
		end else if (tdiv_r != 16'h0000) begin
			tdiv_r <= tdiv_r - 16'h0001;
		end else begin
			tdiv_r <= `UART_DIV;
			case (ts_r)
				host_port_pkg::tx_start: begin
					ts_r    <= host_port_pkg::tx_data;
					tline_r <= tsh_r[0];
					tbit_r  <= 3'h0;
				end
				host_port_pkg::tx_data: begin
					tbit_r <= tbit_r + 3'h1;
					if (tbit_r == `BIT_LAST) begin
						ts_r    <= host_port_pkg::tx_stop;
						tline_r <= 1'b1;
					end else begin
						tline_r <= tsh_r[tbit_r + 3'h1];
					end
				end
				default: ts_r <= host_port_pkg::tx_idle;
			endcase
		end
	end
	assign tx_ready               = (ts_r == host_port_pkg::tx_idle);
	assign serial1_device_to_host = tline_r;
	// ****************************************
	// attention line
	// ****************************************
	wire tx_busy = (ts_r != host_port_pkg::tx_idle);
	wire attn    = rs485_mode ? tx_busy : i2c_pending;
	logic attn_r;
	always_ff @(posedge clk) attn_r <= rst ? 1'b1 : ~attn;
	assign attention_n = attn_r;
	// ****************************************
	// spi slave, mode 0
	// ****************************************
	logic [DATA_W-1:0] spi_sh_r;
	logic              miso_r;
	logic              sel_d_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			spi_sh_r <= '0;
			miso_r   <= 1'b0;
			sel_d_r  <= 1'b0;
		end else begin
			sel_d_r <= spi_sel;
			if (spi_sel & ~sel_d_r) begin
				spi_sh_r <= spi_tx_byte;
				miso_r   <= spi_tx_byte[DATA_W-1];
			end else if (spi_sel & sck_rise) begin
				spi_sh_r <= {spi_sh_r[DATA_W-2:0], mosi_s_r[1]};
			end else if (spi_sel & sck_fall) begin
				miso_r <= spi_sh_r[DATA_W-1];
			end
		end
	end
	assign spi_miso = miso_r;
	// ****************************************
	// switch outputs
	// ****************************************
	logic [PWM_W-1:0] pwm_cnt_r;
	logic             sw0_r, sw1_r;
	always_ff @(posedge clk) begin
		pwm_cnt_r <= rst ? '0 : pwm_cnt_r + 1'b1;
		sw0_r <= ~rst & (switch_pwm_mode[0] ? (pwm_cnt_r < pwm_duty_0) : switch_static[0]);
		sw1_r <= ~rst & (switch_pwm_mode[1] ? (pwm_cnt_r < pwm_duty_1) : switch_static[1]);
	end
	assign switch_out_0 = sw0_r;
	assign switch_out_1 = sw1_r;
	// ****************************************
	// configurable pin functions
	// ****************************************
	// sda has no push-pull: an illegal choice falls back to input
	wire sda_oe = (mode_sda == host_port_pkg::pm_pulldown) |
	              (mode_sda == host_port_pkg::pm_kbcol);
	wire gio_pp = (mode_gio_a == host_port_pkg::pm_pushpull);
	wire gio_oe = gio_pp | (mode_gio_a == host_port_pkg::pm_pulldown) |
	              (mode_gio_a == host_port_pkg::pm_kbcol);
	host_port_pkg::pin_drive_type sda_r, gio_r;
	logic                         ana_r;
	always_ff @(posedge clk) begin
		sda_r <= rst ? '0 : {sda_oe, 1'b0};
		gio_r <= rst ? '0 : {gio_oe, gio_pp & switch_static[0]};
		ana_r <= ~rst & (mode_gio_a == host_port_pkg::pm_analog);
	end
	assign sda_drive           = sda_r;
	assign general_io_a_drive  = gio_r;
	assign general_io_a_analog = ana_r;
	// ****************************************
	// checks
	// ****************************************
	property p_attn_i2c;
		@(posedge clk) disable iff (rst) !rs485_mode && i2c_pending ##1 !rst |-> !attention_n;
	endproperty
	a_attn_i2c: assert property (p_attn_i2c) else $error("attention not low");
	property p_attn_tx;
		@(posedge clk) disable iff (rst) rs485_mode && tx_busy |=> !attention_n;
	endproperty
	a_attn_tx: assert property (p_attn_tx) else $error("attention high in transmit");
	property p_cts;
		@(posedge clk) disable iff (rst) cnt_r == 2'd2 |=> cts_n;
	endproperty
	a_cts: assert property (p_cts) else $error("cts not asserted when full");
	property p_release;
		@(posedge clk) disable iff (rst) !rs485_mode && !i2c_pending |=> attention_n;
	endproperty
	a_release: assert property (p_release) else $error("attention not released");
	property p_sda_no_pp;
		@(posedge clk) disable iff (rst) sda_drive.oe |-> !sda_drive.o;
	endproperty
	a_sda_no_pp: assert property (p_sda_no_pp) else $error("sda driven high");
	property p_sw0;
		@(posedge clk) disable iff (rst) !switch_pwm_mode[0] |=> switch_out_0 == $past(switch_static[0]);
	endproperty
	a_sw0: assert property (p_sw0) else $error("switch 0 wrong");
	property p_ana;
		@(posedge clk) disable iff (rst) general_io_a_analog |-> !general_io_a_drive.oe;
	endproperty
	a_ana: assert property (p_ana) else $error("analog pin driven");
	property p_txidle;
		@(posedge clk) disable iff (rst) tx_ready |-> serial1_device_to_host;
	endproperty
	a_txidle: assert property (p_txidle) else $error("line not idle high");
endmodule

// File: inc/host_port_cfg.svh
// timing, field and reset constants for the host control port
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
`define BUF_DEPTH       2
`define BYTE_W          8
`define PWM_W           8
`define CNT_W           8
`define BIT_LAST        3'h7
`define UART_DIV        16'h0870
`define UART_HALF       16'h0438
`define ZERO8           8'h00
`define PIN_MODE_W      3
`endif

// File: inc/host_port_pkg.sv
// shared types of the host control port
package host_port_pkg;
	typedef enum logic [2:0] {
		pm_primary   = 3'b000,
		pm_din       = 3'b001,
		pm_pushpull  = 3'b010,
		pm_pulldown  = 3'b011,
		pm_kbcol     = 3'b100,
		pm_analog    = 3'b101
	} pin_mode_type;
	typedef struct packed {
		logic oe;
		logic o;
	} pin_drive_type;
	typedef enum logic [1:0] {
		tx_idle  = 2'b00,
		tx_start = 2'b01,
		tx_data  = 2'b10,
		tx_stop  = 2'b11
	} tx_state_type;
endpackage

// File: sim/host_control_port_test.sv
// self-checking bench for the host control port
`timescale 1ns/1ps
module host_control_port_test;
	logic clk, reset, serial1_host_to_device, serial1_device_to_host, cts_n, attention_n;
	logic rs485_mode, i2c_pending, spi_sck, spi_mosi, spi_miso, spi_sel_n, rx_valid, rx_ready;
	logic tx_valid, tx_ready, reset_pin_enable, reset_pin_in, reset_pin_out, reset_pin_oe;
	logic module_reset, erase_request, switch_out_0, switch_out_1, gio_a_level, sda_level;
	logic general_io_a_analog, strap_low;
	logic [1:0] switch_pwm_mode, switch_static;
	logic [7:0] spi_tx_byte, rx_data, tx_data, pwm_duty_0, pwm_duty_1, got;
	host_port_pkg::pin_mode_type mode_sda, mode_gio_a;
	host_port_pkg::pin_drive_type sda_drive, general_io_a_drive;
	logic [31:0] seed = 32'h091c_e8eb;
	int num_errors = 0, n_checks = 0, cycles = 0;
	logic [7:0] rxq[$];
	host_control_port dut (
		.clk                    (clk),
		.reset                  (reset),
		.serial1_host_to_device (serial1_host_to_device),
		.serial1_device_to_host (serial1_device_to_host),
		.cts_n                  (cts_n),
		.attention_n            (attention_n),
		.rs485_mode             (rs485_mode),
		.i2c_pending            (i2c_pending),
		.spi_sck                (spi_sck),
		.spi_mosi               (spi_mosi),
		.spi_miso               (spi_miso),
		.spi_sel_n              (spi_sel_n),
		.spi_tx_byte            (spi_tx_byte),
		.rx_data                (rx_data),
		.rx_valid               (rx_valid),
		.rx_ready               (rx_ready),
		.tx_data                (tx_data),
		.tx_valid               (tx_valid),
		.tx_ready               (tx_ready),
		.reset_pin_enable       (reset_pin_enable),
		.reset_pin_in           (reset_pin_in),
		.reset_pin_out          (reset_pin_out),
		.reset_pin_oe           (reset_pin_oe),
		.module_reset           (module_reset),
		.erase_request          (erase_request),
		.switch_pwm_mode        (switch_pwm_mode),
		.switch_static          (switch_static),
		.pwm_duty_0             (pwm_duty_0),
		.pwm_duty_1             (pwm_duty_1),
		.switch_out_0           (switch_out_0),
		.switch_out_1           (switch_out_1),
		.mode_sda               (mode_sda),
		.mode_gio_a             (mode_gio_a),
		.gio_a_level            (gio_a_level),
		.sda_level              (sda_level),
		.sda_drive              (sda_drive),
		.general_io_a_drive     (general_io_a_drive),
		.general_io_a_analog    (general_io_a_analog)
	);
	host_model host (
		.serial1_host_to_device (serial1_host_to_device),
		.spi_sck                (spi_sck),
		.spi_mosi               (spi_mosi),
		.spi_sel_n              (spi_sel_n),
		.spi_miso               (spi_miso),
		.strap_low              (strap_low)
	);
	initial clk = 1'b0;
	always #2 clk = ~clk;
	// ****************
	// helpers
	// ****************
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] lfsr();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (e !== g) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic uart_tx(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		chk("tx_ready idle", 1, tx_ready);
		tx_data = b;
		tx_valid = 1'b1;
		step();
		tx_valid = 1'b0;
		for (int k = 0; k < 4 && serial1_device_to_host !== 1'b0; k++) step();
		step(1080);
		for (int i = 0; i < 10; i++) begin
			chk("serial out bit", f[i], serial1_device_to_host);
			chk("attention during send", 0, attention_n);
			chk("tx_ready busy", 0, tx_ready);
			step(2161);
		end
		chk("attention after send", 1, attention_n);
	endtask
	// ****************
	// tests
	// ****************
	initial begin
		logic [31:0] r;
		int c0, c1;
		{reset, rs485_mode, i2c_pending, rx_ready, tx_valid, strap_low} = 6'b10_0000;
		{reset_pin_enable, reset_pin_in, gio_a_level, sda_level} = 4'b1100;
		{switch_pwm_mode, switch_static, spi_tx_byte, tx_data} = 20'h0_0000;
		{pwm_duty_0, pwm_duty_1} = 16'h0000;
		mode_sda = host_port_pkg::pm_din;
		mode_gio_a = host_port_pkg::pm_din;
		step();
		chk("reset outputs", 4'b1101, {serial1_device_to_host, attention_n, cts_n, reset_pin_oe});
		chk("reset pin shown", 0, reset_pin_out);
		step();
		reset = 1'b0;
		step(3);
		chk("no erase", 0, erase_request);
		$display("done: reset values");
		i2c_pending = 1'b1;
		step(2);
		chk("attention pending", 0, attention_n);
		i2c_pending = 1'b0;
		step(2);
		chk("attention released", 1, attention_n);
		rs485_mode = 1'b1;
		i2c_pending = 1'b1;
		step(2);
		chk("attention rs485 idle", 1, attention_n);
		$display("done: attention");
		r = lfsr();
		// full duplex; third byte ignores cts so the buffer must drop it
		fork
			uart_tx(r[31:24]);
			for (int i = 0; i < 3; i++) begin
				host.send_uart(r[8*i +: 8]);
				if (rxq.size() < 2) rxq.push_back(r[8*i +: 8]);
				chk("cts stop", 1, cts_n);
			end
		join
		rx_ready = 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (rx_valid === 1'b1) chk("rx byte", rxq.pop_front(), rx_data);
			step();
		end
		chk("rx left", 3'b000, {rxq.size() != 0, rx_valid, cts_n});
		$display("done: serial");
		for (int i = 0; i < 2; i++) begin
			r = lfsr();
			spi_tx_byte = r[31:24];
			// deselect long enough to pass the select synchroniser
			step(4);
			host.spi_xfer(r[7:0], got);
			chk("spi miso byte", r[31:24], got);
		end
		$display("done: spi");
		switch_static = 2'b10;
		step(2);
		chk("switch static", 2'b10, {switch_out_1, switch_out_0});
		r = lfsr();
		pwm_duty_0 = r[7:0];
		pwm_duty_1 = r[15:8];
		switch_pwm_mode = 2'b11;
		step(2);
		c0 = 0;
		c1 = 0;
		repeat (256) begin
			c0 += switch_out_0;
			c1 += switch_out_1;
			step();
		end
		chk("pwm 0 high count", r[7:0], c0);
		chk("pwm 1 high count", r[15:8], c1);
		$display("done: switch outputs");
		mode_sda = host_port_pkg::pm_pushpull;
		step(2);
		chk("gio input", 2'b00, {general_io_a_drive.oe, general_io_a_analog});
		chk("sda no push-pull", 0, sda_drive.oe);
		mode_gio_a = host_port_pkg::pm_pushpull;
		mode_sda = host_port_pkg::pm_pulldown;
		step(2);
		chk("gio push-pull", {1'b1, switch_static[0]}, general_io_a_drive);
		chk("sda pull-down", 2'b10, sda_drive);
		mode_gio_a = host_port_pkg::pm_analog;
		step(2);
		chk("gio analog", 2'b01, {general_io_a_drive.oe, general_io_a_analog});
		mode_gio_a = host_port_pkg::pm_pulldown;
		step(2);
		chk("gio pull-down", 3'b100, {general_io_a_drive, general_io_a_analog});
		mode_gio_a = host_port_pkg::pm_kbcol;
		step(2);
		chk("gio column", 3'b100, {general_io_a_drive, general_io_a_analog});
		$display("done: pin modes");
		reset_pin_enable = 1'b0;
		reset_pin_in = 1'b0;
		step(4);
		chk("pin reset disabled", 0, module_reset);
		reset_pin_enable = 1'b1;
		step(4);
		chk("pin reset", 1, module_reset);
		reset_pin_in = 1'b1;
		step(4);
		chk("pin reset gone", 0, module_reset);
		$display("done: reset pin");
		strap_low = 1'b1;
		reset = 1'b1;
		step(2);
		reset = 1'b0;
		step(3);
		chk("erase strap", 1, erase_request);
		$display("done: erase strap");
		report_and_stop();
	end
endmodule

// File: sim/host_model.sv
// host-side partner: serial 1 sender and spi master
`timescale 1ns/1ps
module host_model (
	output logic      serial1_host_to_device,
	output logic      spi_sck,
	output logic      spi_mosi,
	output logic      spi_sel_n,
	input  wire logic spi_miso,
	input  wire logic strap_low
);
	logic u_r;
	// ****************
	// line drivers
	// ****************
	// strap models the pull-down resistor held through power-up
	assign serial1_host_to_device = strap_low ? 1'b0 : u_r;
	initial begin
		u_r = 1'b1;
		spi_sck = 1'b0;
		spi_mosi = 1'b0;
		spi_sel_n = 1'b1;
	end
	// 8n1, lsb first, 2161 clocks of 4 ns per bit
	task automatic send_uart(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			u_r = f[i];
			#8644;
		end
	endtask
	// mode 0, msb first; sck still outside frames
	task automatic spi_xfer(input logic [7:0] o, output logic [7:0] r);
		spi_sel_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			spi_mosi = o[i];
			#40 spi_sck = 1'b1;
			r[i] = spi_miso;
			#40 spi_sck = 1'b0;
		end
		#40 spi_sel_n = 1'b1;
		// released line: no pull, so show a changed level
		spi_mosi = ~spi_mosi;
	endtask
endmodule
